/* File: uorf_pkg.sv */
// package of offsets, fields and timing for the reset and flush control
`default_nettype none
package uorf_pkg;
  localparam logic [7:0] CFG_OFS = 8'h0C;
  localparam logic [7:0] RST_OFS = 8'h10;
  localparam logic [7:0] INT_OFS = 8'h14;
  localparam int PHY_WIDTH_BIT = 3;
  localparam int TOUT_LSB = 0;
  localparam int TOUT_W = 3;
  localparam int IDLE_BIT = 31;
  localparam int DMA_BIT = 30;
  localparam int TXSEL_LSB = 6;
  localparam int TXSEL_W = 5;
  localparam int TXFL_BIT = 5;
  localparam int RXFL_BIT = 4;
  localparam int INQ_BIT = 3;
  localparam int FRM_BIT = 2;
  localparam int PDM_BIT = 1;
  localparam int CSR_BIT = 0;
  localparam int WAKE_BIT = 31;
  localparam int SESS_BIT = 30;
  localparam int DISC_BIT = 29;
  localparam logic [4:0] TXSEL_ALL = 5'h10;
  localparam logic [4:0] TXSEL_RST = 5'h00;
  localparam logic [2:0] TOUT_RST = 3'h0;
  localparam int FLUSH_SLOW_CYCLES = 8;
  localparam int HS_TOUT_MIN = 736;
  localparam int HS_TOUT_MAX = 816;
  localparam int FS_TOUT_MIN = 16;
  localparam int FS_TOUT_MAX = 18;
  localparam int DWIDTH_BOTH = 3;
  localparam int SOFT_RST_CYCLES = 4;
endpackage
`default_nettype wire

/* File: uorf_top.sv */
// reset, flush and top interrupt status logic of the usb otg core
`default_nettype none
// Operation
// - width bit: 0 is 8-bit, 1 is 16-bit
// - width writable only when width parameter 3
// - calibration clocks added to packet timeout
// - base timeout 736-816 hs, 16-18 fs
// - bit 31 shows master idle
// - bit 30 shows dma request in progress
// - fifo number selects flush target
// - tx flush self-clears after eight slow clocks
// - rx flush self-clears after eight slow clocks
// - token queue flush only without dedicated fifos
// - frame counter reset zeroes next sof
// - power-down module soft reset, self-clearing
// - soft reset clears regs, idles, flushes
// - soft reset waits master data phase
// - power management kept with hibernation enabled
// - wakeup flag, write one to clear
// - session request flag, write one to clear
// - disconnect flag, write one to clear
module uorf_top #(
  parameter int HS_PHY_WIDTH_PARAM = 3,
  parameter logic FIXED_WIDTH = 1'b0,
  parameter bit DEDICATED_TX_FIFO_PARAM = 1'b0,
  parameter bit PMU_KEEP = 1'b0,
  parameter int SLOW_DIV = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  input wire logic masterIdleIn,
  input wire logic masterMidBeat,
  input wire logic dmaReqIn,
  input wire logic hostMode,
  input wire logic inSuspend,
  input wire logic inL1,
  input wire logic hostResumeIn,
  input wire logic remoteWakeIn,
  input wire logic sessReqIn,
  input wire logic bValidPin,
  input wire logic disconnectIn,
  input wire logic isHighSpeed,
  output logic phyWidth16,
  output logic [9:0] toutBitTimes,
  output logic [4:0] txFlushSelect,
  output logic txFlushAll,
  output logic txFlushActive,
  output logic rxFlushActive,
  output logic inTokenQueueFlush,
  output logic frameCounterReset,
  output logic powerDownReset,
  output logic pmuReset,
  output logic coreResetActive,
  output logic usbAbort
);
  // refuse parameter values the logic cannot serve
  if (HS_PHY_WIDTH_PARAM < 0 || HS_PHY_WIDTH_PARAM > 3) begin : g_bad_width
    $error("bad width parameter");
  end
  if (SLOW_DIV < 1 || SLOW_DIV > 256) begin : g_bad_div
    $error("bad slow divider");
  end

  logic widthReg, txFlushReg, rxFlushReg, csrReg;
  logic [2:0] toutReg;
  logic [4:0] txSelReg;
  logic [2:0] wakeReg;
  logic [3:0] txCntReg, rxCntReg;
  logic [2:0] csrCntReg;
  logic [7:0] divReg;
  logic slowTick;
  logic [2:0] bvSync;
  logic bvPrev;
  logic wrCfg, wrRst, wrInt, softClr, csrDone;

  assign wrCfg = regWr && regAddr == uorf_pkg::CFG_OFS;
  assign wrRst = regWr && regAddr == uorf_pkg::RST_OFS;
  assign wrInt = regWr && regAddr == uorf_pkg::INT_OFS;
  assign softClr = csrReg;
  assign csrDone = csrReg && csrCntReg == 3'(uorf_pkg::SOFT_RST_CYCLES)
    && !masterMidBeat;

  // slow clock enable stands for the slower of phy and bus clocks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divReg <= 8'h00;
      slowTick <= 1'b0;
    end else if (divReg == 8'(SLOW_DIV - 1)) begin
      divReg <= 8'h00;
      slowTick <= 1'b1;
    end else begin
      divReg <= divReg + 8'h01;
      slowTick <= 1'b0;
    end
  end

  // configuration tail: width and calibration
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      widthReg <= 1'b0;
      toutReg <= uorf_pkg::TOUT_RST;
    end else if (softClr) begin
      toutReg <= uorf_pkg::TOUT_RST; // width kept over soft reset
    end else if (wrCfg) begin
      toutReg <= regWdata[uorf_pkg::TOUT_LSB +: uorf_pkg::TOUT_W];
      if (HS_PHY_WIDTH_PARAM == uorf_pkg::DWIDTH_BOTH)
        widthReg <= regWdata[uorf_pkg::PHY_WIDTH_BIT];
    end
  end

  // flush bits with eight slow cycle self clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txFlushReg <= 1'b0;
      rxFlushReg <= 1'b0;
      txCntReg <= 4'h0;
      rxCntReg <= 4'h0;
      txSelReg <= uorf_pkg::TXSEL_RST;
    end else if (softClr) begin
      txFlushReg <= 1'b0;
      rxFlushReg <= 1'b0;
      txSelReg <= uorf_pkg::TXSEL_RST;
    end else begin
      if (wrRst && !txFlushReg)
        txSelReg <= regWdata[uorf_pkg::TXSEL_LSB +: uorf_pkg::TXSEL_W];
      if (wrRst && regWdata[uorf_pkg::TXFL_BIT] && !txFlushReg) begin
        txFlushReg <= 1'b1;
        txCntReg <= 4'h0;
      end else if (txFlushReg && slowTick) begin
        txCntReg <= txCntReg + 4'h1;
        if (txCntReg == 4'(uorf_pkg::FLUSH_SLOW_CYCLES - 1))
          txFlushReg <= 1'b0;
      end
      if (wrRst && regWdata[uorf_pkg::RXFL_BIT] && !rxFlushReg) begin
        rxFlushReg <= 1'b1;
        rxCntReg <= 4'h0;
      end else if (rxFlushReg && slowTick) begin
        rxCntReg <= rxCntReg + 4'h1;
        if (rxCntReg == 4'(uorf_pkg::FLUSH_SLOW_CYCLES - 1))
          rxFlushReg <= 1'b0;
      end
    end
  end

  // core soft reset sequence, held until the master beat finishes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      csrReg <= 1'b0;
      csrCntReg <= 3'h0;
    end else if (csrReg) begin
      if (csrDone)
        csrReg <= 1'b0;
      else if (csrCntReg != 3'(uorf_pkg::SOFT_RST_CYCLES))
        csrCntReg <= csrCntReg + 3'h1;
    end else if (wrRst && regWdata[uorf_pkg::CSR_BIT]) begin
      csrReg <= 1'b1;
      csrCntReg <= 3'h0;
    end
  end

  // one-cycle command strobes; pmu reset is held for the whole soft reset unless PMU_KEEP is set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inTokenQueueFlush <= 1'b0;
      frameCounterReset <= 1'b0;
      powerDownReset <= 1'b0;
      pmuReset <= 1'b0;
      usbAbort <= 1'b0;
    end else begin
      inTokenQueueFlush <= wrRst && regWdata[uorf_pkg::INQ_BIT]
        && !DEDICATED_TX_FIFO_PARAM;
      frameCounterReset <= wrRst && regWdata[uorf_pkg::FRM_BIT];
      powerDownReset <= wrRst && regWdata[uorf_pkg::PDM_BIT];
      pmuReset <= csrReg && !PMU_KEEP;
      usbAbort <= wrRst && regWdata[uorf_pkg::CSR_BIT] && !csrReg;
    end
  end

  // b-session valid pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvSync <= 3'b000;
      bvPrev <= 1'b0;
    end else begin
      bvSync <= {bvSync[1:0], bValidPin};
      if (bvSync[1] == bvSync[2])
        bvPrev <= bvSync[2];
    end
  end

  // sticky status: set wins over write-one-to-clear
  logic wakeSet, sessSet, discSet;
  assign wakeSet = inL1 ? (hostResumeIn || remoteWakeIn)
    : inSuspend && (hostMode ? remoteWakeIn : hostResumeIn);
  assign sessSet = hostMode ? sessReqIn
    : (bvSync[1] && bvSync[2] && !bvPrev);
  assign discSet = disconnectIn;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeReg <= 3'b000;
    end else begin
      wakeReg[2] <= wakeSet || (wakeReg[2] && !softClr
        && !(wrInt && regWdata[uorf_pkg::WAKE_BIT]));
      wakeReg[1] <= sessSet || (wakeReg[1] && !softClr
        && !(wrInt && regWdata[uorf_pkg::SESS_BIT]));
      wakeReg[0] <= discSet || (wakeReg[0] && !softClr
        && !(wrInt && regWdata[uorf_pkg::DISC_BIT]));
    end
  end

  // read data mux
  logic widthEff;
  assign widthEff = (HS_PHY_WIDTH_PARAM == uorf_pkg::DWIDTH_BOTH)
    ? widthReg : FIXED_WIDTH;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      regRdata <= 32'h0000_0000;
      unique case (regAddr)
        uorf_pkg::CFG_OFS: begin
          regRdata[uorf_pkg::PHY_WIDTH_BIT] <= widthEff;
          regRdata[uorf_pkg::TOUT_LSB +: uorf_pkg::TOUT_W] <= toutReg;
        end
        uorf_pkg::RST_OFS: begin
          regRdata[uorf_pkg::IDLE_BIT] <= masterIdleIn && !csrReg;
          regRdata[uorf_pkg::DMA_BIT] <= dmaReqIn;
          regRdata[uorf_pkg::TXSEL_LSB +: uorf_pkg::TXSEL_W] <= txSelReg;
          regRdata[uorf_pkg::TXFL_BIT] <= txFlushReg;
          regRdata[uorf_pkg::RXFL_BIT] <= rxFlushReg;
          regRdata[uorf_pkg::CSR_BIT] <= csrReg;
        end
        uorf_pkg::INT_OFS: begin
          regRdata[uorf_pkg::WAKE_BIT] <= wakeReg[2];
          regRdata[uorf_pkg::SESS_BIT] <= wakeReg[1];
          regRdata[uorf_pkg::DISC_BIT] <= wakeReg[0];
        end
        default: regRdata <= 32'h0000_0000;
      endcase
    end
  end

  // block outputs, all registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phyWidth16 <= 1'b0;
      toutBitTimes <= 10'h000;
      txFlushSelect <= uorf_pkg::TXSEL_RST;
      txFlushAll <= 1'b0;
      txFlushActive <= 1'b0;
      rxFlushActive <= 1'b0;
      coreResetActive <= 1'b0;
    end else begin
      phyWidth16 <= widthEff;
      toutBitTimes <= (isHighSpeed ? 10'(uorf_pkg::HS_TOUT_MIN)
        : 10'(uorf_pkg::FS_TOUT_MIN)) + {7'h00, toutReg};
      txFlushSelect <= txSelReg;
      txFlushAll <= txSelReg == uorf_pkg::TXSEL_ALL;
      txFlushActive <= txFlushReg || csrReg;
      rxFlushActive <= rxFlushReg || csrReg;
      coreResetActive <= csrReg;
    end
  end

  a_tx_flush_len: assert property (@(posedge ref_clk)
    disable iff (!rst_n) $rose(txFlushReg) && !csrReg |-> txFlushReg [*8])
    else $error("tx flush cleared too early");
  a_rx_flush_len: assert property (@(posedge ref_clk)
    disable iff (!rst_n) $rose(rxFlushReg) && !csrReg |-> rxFlushReg [*8])
    else $error("rx flush cleared too early");
  a_tx_flush_end: assert property (@(posedge ref_clk)
    disable iff (!rst_n) $rose(txFlushReg) |-> ##[1:40] !txFlushReg)
    else $error("tx flush never cleared");
  a_csr_beat: assert property (@(posedge ref_clk)
    disable iff (!rst_n) csrReg && masterMidBeat |=> csrReg)
    else $error("soft reset ended mid beat");
  a_frame_strobe: assert property (@(posedge ref_clk)
    disable iff (!rst_n) wrRst && regWdata[uorf_pkg::FRM_BIT]
    |=> frameCounterReset)
    else $error("frame reset missing");
  a_disc_sticky: assert property (@(posedge ref_clk)
    disable iff (!rst_n) discSet |=> wakeReg[0])
    else $error("disconnect lost");
  a_wake_sticky: assert property (@(posedge ref_clk)
    disable iff (!rst_n) wakeSet |=> wakeReg[2])
    else $error("wakeup lost");
  a_token_queue: assert property (@(posedge ref_clk)
    disable iff (!rst_n) wrRst && regWdata[uorf_pkg::INQ_BIT]
    |=> inTokenQueueFlush == !DEDICATED_TX_FIFO_PARAM)
    else $error("token flush does not follow fifo build");
  c_tx_flush: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(txFlushReg));
  c_soft_reset: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(csrReg));
  c_sess_device: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sessSet && !hostMode);
endmodule
`default_nettype wire

/* File: uorf_link_model.sv */
// link and bus master stand-in driving the core's event inputs
`default_nettype none
module uorf_link_model (
  input wire logic ref_clk,
  input wire logic evtGo,
  input wire logic [2:0] evtCode,
  input wire logic busy,
  output logic hostResumeIn,
  output logic remoteWakeIn,
  output logic sessReqIn,
  output logic bValidPin,
  output logic disconnectIn,
  output logic masterIdleIn,
  output logic masterMidBeat,
  output logic dmaReqIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle bus events, picked by code; valid pin only rises
  always @(posedge ref_clk) begin
    hostResumeIn <= evtGo && evtCode == 3'h0;
    remoteWakeIn <= evtGo && evtCode == 3'h1;
    sessReqIn <= evtGo && evtCode == 3'h2;
    disconnectIn <= evtGo && evtCode == 3'h3;
    if (evtGo && evtCode == 3'h4) begin
      bValidPin <= 1'b1;
    end
  end
  initial begin
    {hostResumeIn, remoteWakeIn, sessReqIn, disconnectIn} = 4'h0;
    bValidPin = 1'b0;
  end
  // a busy master sits in a data phase with dma pending
  assign masterMidBeat = busy;
  assign masterIdleIn = !busy;
  assign dmaReqIn = busy;
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the reset and flush control
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWr = 1'b0, regRd = 1'b0, evtGo = 1'b0, busy = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000, regRdata;
  logic hostMode = 1'b0, inSuspend = 1'b0, inL1 = 1'b0, isHighSpeed = 1'b1;
  logic [2:0] evtCode = 3'h0, busyVec;
  logic hostResumeIn, remoteWakeIn, sessReqIn, bValidPin, disconnectIn;
  logic masterIdleIn, masterMidBeat, dmaReqIn, phyWidth16, txFlushAll;
  logic txFlushActive, rxFlushActive, inTokenQueueFlush, frameCounterReset;
  logic powerDownReset, pmuReset, coreResetActive, usbAbort;
  logic [9:0] toutBitTimes;
  logic [4:0] txFlushSelect, seen = 5'h00;
  logic [4:0] sels [4] = '{5'h00, 5'h01, 5'h0F, 5'h10};
  int errTotal = 0, totalChecks = 0, n;
  always #20 ref_clk = ~ref_clk;
  uorf_top #(.HS_PHY_WIDTH_PARAM(3), .SLOW_DIV(2)) dut_u (.ref_clk, .rst_n,
    .regWr, .regRd, .regAddr, .regWdata, .regRdata, .masterIdleIn,
    .masterMidBeat, .dmaReqIn, .hostMode, .inSuspend, .inL1, .hostResumeIn,
    .remoteWakeIn, .sessReqIn, .bValidPin, .disconnectIn, .isHighSpeed,
    .phyWidth16, .toutBitTimes, .txFlushSelect, .txFlushAll, .txFlushActive,
    .rxFlushActive, .inTokenQueueFlush, .frameCounterReset, .powerDownReset,
    .pmuReset, .coreResetActive, .usbAbort);
  uorf_link_model link_u (.ref_clk, .evtGo, .evtCode, .busy, .hostResumeIn,
    .remoteWakeIn, .sessReqIn, .bValidPin, .disconnectIn, .masterIdleIn,
    .masterMidBeat, .dmaReqIn);
  // sticky record of the one-cycle strobes and the held pmu reset
  always @(posedge ref_clk) begin
    if (rst_n) begin
      seen <= seen | {pmuReset, usbAbort, powerDownReset, inTokenQueueFlush,
        frameCounterReset};
    end
  end
  assign busyVec = {coreResetActive, rxFlushActive, txFlushActive};
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic closeOut;
    $display("checks %0d errors %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  task automatic evt(input logic [2:0] c);
    @(posedge ref_clk);
    evtGo <= 1'b1;
    evtCode <= c;
    @(posedge ref_clk);
    evtGo <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // bounded wait for a self-clearing bit, n counts cycles
  task automatic waitClr(input int i);
    n = 0;
    while (busyVec[i] !== 1'b0 && n < 60) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n == 60) begin
      errTotal++;
      closeOut;
    end
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(uorf_pkg::CFG_OFS, 32'h0000_000D);
    rd(uorf_pkg::CFG_OFS, 32'h0000_000D);
    chk({31'h0, phyWidth16}, 32'h0000_0001);
    chk({22'h0, toutBitTimes}, 32'h0000_02E5);
    @(posedge ref_clk) isHighSpeed <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk({22'h0, toutBitTimes}, 32'h0000_0015);
    rd(8'h20, 32'h0000_0000);
    rd(uorf_pkg::RST_OFS, 32'h8000_0000);
    @(posedge ref_clk) busy <= 1'b1;
    rd(uorf_pkg::RST_OFS, 32'h4000_0000);
    @(posedge ref_clk) busy <= 1'b0;
    // tx flush per target class, select held until the bit clears
    foreach (sels[k]) begin
      wr(uorf_pkg::RST_OFS, {21'h0, sels[k], 6'h20});
      @(posedge ref_clk);
      #1;
      chk({27'h0, txFlushSelect}, {27'h0, sels[k]});
      chk({31'h0, txFlushAll}, {31'h0, sels[k] == 5'h10});
      chk({31'h0, txFlushActive}, 32'h0000_0001);
      waitClr(0);
      chk({31'h0, n >= 14 && n <= 18}, 32'h0000_0001);
    end
    wr(uorf_pkg::RST_OFS, 32'h0000_0010);
    rd(uorf_pkg::RST_OFS, 32'h8000_0010);
    waitClr(1);
    rd(uorf_pkg::RST_OFS, 32'h8000_0000);
    wr(uorf_pkg::RST_OFS, 32'h0000_000E);
    rd(uorf_pkg::RST_OFS, 32'h8000_0000);
    chk({29'h0, seen[2:0]}, 32'h0000_0007);
    // wakeup, session and disconnect flags per mode
    @(posedge ref_clk) inSuspend <= 1'b1;
    evt(3'h1);
    rd(uorf_pkg::INT_OFS, 32'h0000_0000);
    evt(3'h0);
    rd(uorf_pkg::INT_OFS, 32'h8000_0000);
    wr(uorf_pkg::INT_OFS, 32'h8000_0000);
    rd(uorf_pkg::INT_OFS, 32'h0000_0000);
    @(posedge ref_clk) hostMode <= 1'b1;
    evt(3'h2);
    rd(uorf_pkg::INT_OFS, 32'h4000_0000);
    wr(uorf_pkg::INT_OFS, 32'h4000_0000);
    hostMode <= 1'b0;
    evt(3'h4);
    evt(3'h3);
    rd(uorf_pkg::INT_OFS, 32'h6000_0000);
    @(posedge ref_clk);
    inSuspend <= 1'b0;
    inL1 <= 1'b1;
    hostMode <= 1'b1;
    evt(3'h1);
    rd(uorf_pkg::INT_OFS, 32'hE000_0000);
    // soft reset while the master is mid data phase
    @(posedge ref_clk) busy <= 1'b1;
    wr(uorf_pkg::RST_OFS, 32'h0000_0001);
    repeat (8) @(posedge ref_clk);
    #1 chk({31'h0, coreResetActive}, 32'h0000_0001);
    @(posedge ref_clk) busy <= 1'b0;
    waitClr(2);
    chk({27'h0, seen}, 32'h0000_001F);
    repeat (3) @(posedge ref_clk);
    rd(uorf_pkg::RST_OFS, 32'h8000_0000);
    rd(uorf_pkg::INT_OFS, 32'h0000_0000);
    rd(uorf_pkg::CFG_OFS, 32'h0000_0008);
    closeOut;
  end
endmodule
`default_nettype wire
